//--- hw/fcd_regs.svh
`ifndef FCD_REGS_SVH
`define FCD_REGS_SVH

// Command bytes seen on the low data byte
`define FCD_CMD_RESET      8'hf0
`define FCD_CMD_UNLOCK_A   8'haa
`define FCD_CMD_UNLOCK_B   8'h55
`define FCD_CMD_IDENT      8'h90
`define FCD_CMD_PROGRAM    8'ha0
`define FCD_CMD_BYPASS     8'h20
`define FCD_CMD_ERASE_SET  8'h80
`define FCD_CMD_CHIP_ERASE 8'h10
`define FCD_CMD_SECT_ERASE 8'h30
`define FCD_CMD_RESUME     8'h30
`define FCD_CMD_SUSPEND    8'hb0
`define FCD_CMD_READ_MODE  8'hc0
`define FCD_CMD_BYP_EXIT   8'h00

// Unlock addresses on the low eleven address bits
`define FCD_ADDR_UNLOCK_A  11'h555
`define FCD_ADDR_UNLOCK_B  11'h2aa

// Identification read offsets on the low address byte
`define FCD_ID_OFS_MAKER   8'h00
`define FCD_ID_OFS_PART    8'h01
`define FCD_ID_OFS_PROT    8'h02
`define FCD_ID_OFS_MODE    8'h03

// Identification values, arbitrary neutral codes
`define FCD_ID_MAKER       16'h00a5
`define FCD_ID_PART        16'h5a3c

// Field positions
`define FCD_POLL_BIT       7
`define FCD_FAIL_BIT       5
`define FCD_SECT_MSB       18
`define FCD_SECT_LSB       12

// Timing: clock period and status hold times in ns
`define FCD_CLK_NS         8
`define FCD_PROG_PROT_NS   1000
`define FCD_ERASE_PROT_NS  100000

`endif

//--- hw/fcd_pkg.sv
package fcd_pkg;

  // Command decoder position, Gray coded along the unlock path
  typedef enum logic [3:0] {
    FCD_IDLE     = 4'h0,
    FCD_U1       = 4'h1,
    FCD_U2       = 4'h3,
    FCD_E3       = 4'h2,
    FCD_E4       = 4'h6,
    FCD_E5       = 4'h7,
    FCD_PROG_D   = 4'h5,
    FCD_BYP_PROG = 4'h4,
    FCD_MODE_D   = 4'hc,
    FCD_BYP_RST  = 4'hd
  } fcd_step_t;

  // Address and data pair of one bus word
  typedef struct packed {
    logic [18:0] addr;
    logic [15:0] data;
  } fcd_word_t;

endpackage

//--- hw/fcd_top.sv
// The address map and strobed register access were decided locally.
`timescale 1ns/1ns
`include "fcd_regs.svh"

module fcd_top #(
  parameter int ERASE_PROT_CYC = `FCD_ERASE_PROT_NS / `FCD_CLK_NS
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              reset_n,
  // Flash bus pins
  input  wire logic [18:0]       addr_pin,
  input  wire logic [15:0]       dq_in,
  input  wire logic              chip_select_n,
  input  wire logic              write_strobe_n,
  input  wire logic              output_enable_n,
  output logic      [15:0]       dq_out,
  output logic                   dq_oe,
  // Sector protection state
  input  wire logic [127:0]      sector_protect,
  // Array read port
  output logic      [18:0]       array_addr,
  input  wire logic [15:0]       array_rdata,
  // Embedded algorithm control
  output fcd_pkg::fcd_word_t     op_word,
  output logic      [127:0]      erase_sel,
  output logic                   prog_start,
  output logic                   erase_start,
  output logic                   erase_suspend,
  output logic                   burst_mode,
  input  wire logic              algo_done,
  input  wire logic              algo_fail
);
  import fcd_pkg::*;

  localparam int PROG_PROT_CYC = `FCD_PROG_PROT_NS / `FCD_CLK_NS;

  logic [37:0]  pin_meta, pin_sync;         // Synchroniser stages 1 and 2
  logic [18:0]  addr_s;        // Synchronised address
  logic [15:0]  dq_s;          // Synchronised data
  logic         wr_act, rd_act;             // Write and read cycle seen
  logic         wr_act_q, wr_end;           // Last write activity, write end
  fcd_word_t    wr_word;       // Latched write address and data
  fcd_step_t    step;          // Decoder position
  fcd_step_t    next_step;     // Decoder position after this write
  logic         id_mode, bypass;            // Identification, bypass modes
  logic         prog_act, erase_act, susp;  // Program, erase, suspended
  logic         chip_erase, fake;           // Chip erase, status-only run
  logic [13:0]  timer;         // Protected status hold counter
  logic [127:0] erase_tgt;     // Sectors named by the erase
  logic [15:0]  rd_mux;        // Read value before output flop
  logic [7:0]   cmd;           // Command byte
  logic [10:0]  low_addr;      // Command address bits
  logic [6:0]   wr_sect, rd_sect;           // Sector of write and read
  logic         busy, op_done;              // Running, finished
  logic         go_reset, go_id, go_prog;   // Reset, identify, program
  logic         go_erase, go_chip, go_susp; // Erase, chip erase, suspend
  logic         go_resume, go_bypass;       // Resume, bypass entry
  logic         go_byp_exit, go_mode;       // Bypass exit, mode change
  logic [127:0] sect_onehot, next_tgt;      // Write sector, new erase set

  // Pin synchroniser, strobes idle high
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_meta <= {35'h0_0000_0000, 3'h7};
      pin_sync <= {35'h0_0000_0000, 3'h7};
    end else begin
      pin_meta <= {addr_pin, dq_in, chip_select_n, write_strobe_n,
                   output_enable_n};
      pin_sync <= pin_meta;
    end
  end

  // Decode synchronised pins
  assign addr_s = pin_sync[37:19];
  assign dq_s   = pin_sync[18:3];
  assign wr_act = !pin_sync[2] && !pin_sync[1];
  assign rd_act = !pin_sync[2] && !pin_sync[0] && pin_sync[1];
  assign wr_end = wr_act_q && !wr_act;

  // Write capture: address at start, data tracked till strobe rises
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_act_q <= 1'b0;
      wr_word  <= '0;
    end else begin
      wr_act_q <= wr_act;
      if (wr_act && !wr_act_q) begin
        wr_word.addr <= addr_s;
      end
      if (wr_act) begin
        wr_word.data <= dq_s;
      end
    end
  end

  // Command fields, upper bits dropped
  assign cmd      = wr_word.data[7:0];
  assign low_addr = wr_word.addr[10:0];
  assign wr_sect  = wr_word.addr[`FCD_SECT_MSB:`FCD_SECT_LSB];
  assign busy     = prog_act || (erase_act && !susp);

  // One-hot sector for sector erase
  always_comb begin
    sect_onehot          = '0;
    sect_onehot[wr_sect] = 1'b1;
  end

  // Command decoder
  always_comb begin
    next_step   = step;
    go_reset    = 1'b0;
    go_id       = 1'b0;
    go_prog     = 1'b0;
    go_erase    = 1'b0;
    go_chip     = 1'b0;
    go_susp     = 1'b0;
    go_resume   = 1'b0;
    go_bypass   = 1'b0;
    go_byp_exit = 1'b0;
    go_mode     = 1'b0;
    if (wr_end) begin
      if (busy) begin
        // Only a suspend of an async sector erase is heard
        if (erase_act && !chip_erase && !burst_mode
            && cmd == `FCD_CMD_SUSPEND) begin
          go_susp = 1'b1;
        end
      end else if (cmd == `FCD_CMD_RESET && step != FCD_PROG_D
                   && step != FCD_BYP_PROG) begin
        go_reset  = 1'b1;
        next_step = FCD_IDLE;
      end else begin
        next_step = FCD_IDLE;
        case (step)
          FCD_IDLE: begin
            if (bypass && cmd == `FCD_CMD_PROGRAM) begin
              next_step = FCD_BYP_PROG;
            end else if (bypass && cmd == `FCD_CMD_IDENT) begin
              next_step = FCD_BYP_RST;
            end else if (!bypass && cmd == `FCD_CMD_UNLOCK_A
                         && low_addr == `FCD_ADDR_UNLOCK_A) begin
              next_step = FCD_U1;
            end else if (susp && cmd == `FCD_CMD_RESUME) begin
              go_resume = 1'b1;
            end
          end
          FCD_U1: begin
            if (cmd == `FCD_CMD_UNLOCK_B
                && low_addr == `FCD_ADDR_UNLOCK_B) begin
              next_step = FCD_U2;
            end
          end
          FCD_U2: begin
            if (low_addr == `FCD_ADDR_UNLOCK_A) begin
              case (cmd)
                `FCD_CMD_IDENT:     go_id = 1'b1;
                `FCD_CMD_PROGRAM:   next_step = FCD_PROG_D;
                `FCD_CMD_BYPASS:    go_bypass = !susp;
                `FCD_CMD_ERASE_SET: next_step = susp ? FCD_IDLE : FCD_E3;
                `FCD_CMD_READ_MODE: next_step = susp ? FCD_IDLE : FCD_MODE_D;
                default:            next_step = FCD_IDLE;
              endcase
            end
          end
          FCD_E3: begin
            if (cmd == `FCD_CMD_UNLOCK_A
                && low_addr == `FCD_ADDR_UNLOCK_A) begin
              next_step = FCD_E4;
            end
          end
          FCD_E4: begin
            if (cmd == `FCD_CMD_UNLOCK_B
                && low_addr == `FCD_ADDR_UNLOCK_B) begin
              next_step = FCD_E5;
            end
          end
          FCD_E5: begin
            if (cmd == `FCD_CMD_CHIP_ERASE
                && low_addr == `FCD_ADDR_UNLOCK_A) begin
              go_erase = 1'b1;
              go_chip  = 1'b1;
            end else if (cmd == `FCD_CMD_SECT_ERASE) begin
              go_erase = 1'b1;
            end
          end
          FCD_PROG_D, FCD_BYP_PROG: begin
            // Suspended sectors cannot be programmed
            go_prog = !(susp && erase_sel[wr_sect]);
          end
          FCD_MODE_D: begin
            go_mode = 1'b1;
          end
          FCD_BYP_RST: begin
            go_byp_exit = (cmd == `FCD_CMD_BYP_EXIT);
          end
          default: begin
            next_step = FCD_IDLE;
          end
        endcase
      end
    end
  end

  // Decoder position
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      step <= FCD_IDLE;
    end else begin
      step <= next_step;
    end
  end

  // Read and command modes
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      id_mode    <= 1'b0;
      bypass     <= 1'b0;
      burst_mode <= 1'b0;
    end else begin
      if (go_id) begin
        id_mode <= 1'b1;
      end else if (go_reset) begin
        id_mode <= 1'b0;
      end
      if (go_bypass) begin
        bypass <= 1'b1;
      end else if (go_byp_exit) begin
        bypass <= 1'b0;
      end
      if (go_mode && wr_word.data[0]) begin
        burst_mode <= 1'b1;
      end else if (go_mode && wr_word.data == 16'h0000) begin
        burst_mode <= 1'b0;
      end
    end
  end

  // Erase target set for a new erase
  assign next_tgt = go_chip ? {128{1'b1}} : sect_onehot;
  // Finish: algorithm report, or end of protected status hold
  assign op_done  = fake ? (timer == 14'h0000) : algo_done;

  // Operation tracking and algorithm handshake
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prog_act      <= 1'b0;
      erase_act     <= 1'b0;
      susp          <= 1'b0;
      chip_erase    <= 1'b0;
      fake          <= 1'b0;
      timer         <= 14'h0000;
      op_word       <= '0;
      erase_tgt     <= '0;
      erase_sel     <= '0;
      prog_start    <= 1'b0;
      erase_start   <= 1'b0;
      erase_suspend <= 1'b0;
    end else begin
      prog_start  <= 1'b0;
      erase_start <= 1'b0;
      if (fake && timer != 14'h0000) begin
        timer <= timer - 14'h0001;
      end
      if (go_prog) begin
        // Status is live from the closing write edge
        prog_act <= 1'b1;
        op_word  <= wr_word;
        if (sector_protect[wr_sect]) begin
          fake  <= 1'b1;
          timer <= 14'(PROG_PROT_CYC - 1);
        end else begin
          prog_start <= 1'b1;
        end
      end else if (go_erase) begin
        erase_act  <= 1'b1;
        chip_erase <= go_chip;
        erase_tgt  <= next_tgt;
        erase_sel  <= next_tgt & ~sector_protect;
        if ((next_tgt & ~sector_protect) == '0) begin
          fake  <= 1'b1;
          timer <= 14'(ERASE_PROT_CYC - 1);
        end else begin
          erase_start <= 1'b1;
        end
      end else if (go_susp) begin
        // Suspend takes effect at once, well inside the bound
        susp          <= 1'b1;
        erase_suspend <= 1'b1;
      end else if (go_resume) begin
        susp          <= 1'b0;
        erase_suspend <= 1'b0;
      end else if (op_done && prog_act) begin
        prog_act <= 1'b0;
        fake     <= 1'b0;
      end else if (op_done && erase_act && !susp) begin
        erase_act  <= 1'b0;
        chip_erase <= 1'b0;
        fake       <= 1'b0;
        erase_tgt  <= '0;
        erase_sel  <= '0;
      end
    end
  end

  // Read value selection
  assign rd_sect = array_addr[`FCD_SECT_MSB:`FCD_SECT_LSB];
  always_comb begin
    rd_mux = array_rdata;
    if (id_mode) begin
      case (array_addr[7:0])
        `FCD_ID_OFS_MAKER: rd_mux = `FCD_ID_MAKER;
        `FCD_ID_OFS_PART:  rd_mux = `FCD_ID_PART;
        `FCD_ID_OFS_PROT:  rd_mux = {15'h0000, sector_protect[rd_sect]};
        `FCD_ID_OFS_MODE:  rd_mux = {15'h0000, burst_mode};
        default:           rd_mux = 16'h0000;
      endcase
    end else if (prog_act && array_addr == op_word.addr) begin
      // Polling bit may differ from the other bits of the word
      rd_mux[`FCD_POLL_BIT] = !op_word.data[`FCD_POLL_BIT];
      rd_mux[`FCD_FAIL_BIT] = algo_fail && !fake;
    end else if (erase_act && erase_tgt[rd_sect]) begin
      rd_mux[`FCD_POLL_BIT] = susp;
      rd_mux[`FCD_FAIL_BIT] = algo_fail && !fake && !susp;
    end
  end

  // Read path: address to array, value to the data pins
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      array_addr <= 19'h0_0000;
      dq_out     <= 16'h0000;
      dq_oe      <= 1'b0;
    end else begin
      array_addr <= addr_s;
      dq_oe      <= rd_act;
      dq_out     <= rd_act ? rd_mux : 16'h0000;
    end
  end

endmodule // fcd_top

//--- verif/fcd_props.sv
`timescale 1ns/1ns
module fcd_props (
  // Clock and reset
  input wire logic               clk,
  input wire logic               reset_n,
  // Bus pins
  input wire logic [18:0]        addr_pin,
  input wire logic [15:0]        dq_in,
  input wire logic               chip_select_n,
  input wire logic               write_strobe_n,
  input wire logic               output_enable_n,
  input wire logic               dq_oe,
  // Algorithm side
  input wire logic [127:0]       sector_protect,
  input wire fcd_pkg::fcd_word_t op_word,
  input wire logic [127:0]       erase_sel,
  input wire logic               prog_start,
  input wire logic               erase_start,
  input wire logic               erase_suspend,
  input wire logic               burst_mode
);
  import fcd_pkg::*;
  logic        wr_q;  // Write seen on pins last cycle
  logic [18:0] la;    // Address at start of last write
  logic [15:0] ld;    // Data at end of last write
  logic        wr;    // Both strobes low
  logic        rd;    // Read cycle on pins
  assign wr = !chip_select_n && !write_strobe_n;
  assign rd = !chip_select_n && !output_enable_n && write_strobe_n;
  // Track the last write on the raw pins
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_q <= 1'b0;
      la   <= '0;
      ld   <= '0;
    end else begin
      wr_q <= wr;
      if (wr && !wr_q) la <= addr_pin;
      if (wr) ld <= dq_in;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  prog_pulse_a: assert property (prog_start |=> !prog_start)
    else $error("program start too long");
  prog_word_a: assert property (prog_start |-> op_word == {la, ld})
    else $error("program word not latched");
  prog_prot_a: assert property (
    prog_start |-> !sector_protect[op_word.addr[18:12]])
    else $error("program in protected sector");
  erase_cmd_a: assert property (
    erase_start |-> !prog_start && ld[7:0] inside {8'h10, 8'h30})
    else $error("erase without erase command");
  sect_sel_a: assert property (
    erase_start && ld[7:0] == 8'h30 |=> erase_sel == 128'h1 << la[18:12])
    else $error("wrong sector chosen");
  erase_prot_a: assert property (
    erase_start |=> (erase_sel & sector_protect) == '0)
    else $error("protected sector erased");
  susp_cmd_a: assert property (
    $rose(erase_suspend) |-> ld[7:0] == 8'hb0 && !burst_mode)
    else $error("suspend without command");
  resume_cmd_a: assert property (
    $fell(erase_suspend) |-> ld[7:0] == 8'h30)
    else $error("resume without command");
  burst_cmd_a: assert property (
    $changed(burst_mode) |-> burst_mode == ld[0])
    else $error("read mode changed wrongly");
  oe_cause_a: assert property (dq_oe |-> $past(rd, 3))
    else $error("data driven outside a read");
  oe_on_a: assert property (rd [*4] |-> dq_oe)
    else $error("read data not driven");
  cover property (prog_start);
  cover property (erase_start ##[1:300] $rose(erase_suspend));
  cover property ($fell(burst_mode));
endmodule // fcd_props

//--- verif/fcd_array_model.sv
`timescale 1ns/1ns
module fcd_array_model #(
  parameter int PROG_CYC  = 40, // Program run time
  parameter int ERASE_CYC = 80  // Erase run time
) (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               reset_n,
  // Array port
  input  wire logic [18:0]        array_addr,
  output logic      [15:0]        array_rdata,
  // Algorithm control
  input  wire fcd_pkg::fcd_word_t op_word,
  input  wire logic [127:0]       erase_sel,
  input  wire logic               prog_start,
  input  wire logic               erase_start,
  input  wire logic               erase_suspend,
  output logic                    algo_done,
  output logic                    algo_fail
);
  import fcd_pkg::*;
  logic [15:0] mem [0:524287]; // Array words
  int          pc;             // Program cycles left
  int          ec;             // Erase cycles left
  // Fresh array holds an address pattern
  initial begin
    for (int i = 0; i < 524288; i++) mem[i] = 16'(i) ^ 16'h3c3c;
  end
  assign array_rdata = mem[array_addr];
  assign algo_fail   = 1'b0; // No timing failures modelled
  // Program and erase runs; erase stalls while suspended
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pc = 0;
      ec = 0;
      algo_done <= 1'b0;
    end else begin
      algo_done <= 1'b0;
      if (prog_start) pc = PROG_CYC;
      else if (pc > 0) begin
        pc--;
        if (pc == 0) begin
          mem[op_word.addr] = op_word.data;
          algo_done <= 1'b1;
        end
      end
      if (erase_start) ec = ERASE_CYC;
      else if (ec > 0 && pc == 0 && !erase_suspend) begin
        ec--;
        if (ec == 0) begin
          for (int s = 0; s < 128; s++)
            if (erase_sel[s])
              for (int j = 0; j < 4096; j++) mem[s*4096+j] = 16'hffff;
          algo_done <= 1'b1;
        end
      end
    end
  end
endmodule // fcd_array_model

//--- verif/tb.sv
`timescale 1ns/1ns
`include "fcd_regs.svh"
module tb;
  import fcd_pkg::*;
  // Pins and array side
  logic clk, reset_n, chip_select_n, write_strobe_n, output_enable_n;
  logic dq_oe, prog_start, erase_start, erase_suspend, burst_mode;
  logic algo_done, algo_fail;
  logic [18:0] addr_pin, array_addr;
  logic [15:0] dq_in, dq_out, array_rdata, rd;
  logic [127:0] sector_protect, erase_sel;
  fcd_word_t op_word;
  int errors, cmp_count, cycles;
  // Identification reads and their values
  logic [18:0] id_a [5] = '{19'h0_0000, 19'h0_0001, 19'h0_5002,
                            19'h0_6002, 19'h0_0003};
  logic [15:0] id_e [5] = '{`FCD_ID_MAKER, `FCD_ID_PART, 16'h0001,
                            16'h0000, 16'h0000};
  fcd_top #(.ERASE_PROT_CYC(40)) i_dut (
    .clk(clk), .reset_n(reset_n), .addr_pin(addr_pin), .dq_in(dq_in),
    .chip_select_n(chip_select_n), .write_strobe_n(write_strobe_n),
    .output_enable_n(output_enable_n), .dq_out(dq_out), .dq_oe(dq_oe),
    .sector_protect(sector_protect), .array_addr(array_addr),
    .array_rdata(array_rdata), .op_word(op_word), .erase_sel(erase_sel),
    .prog_start(prog_start), .erase_start(erase_start),
    .erase_suspend(erase_suspend), .burst_mode(burst_mode),
    .algo_done(algo_done), .algo_fail(algo_fail));
  fcd_array_model i_array (
    .clk(clk), .reset_n(reset_n), .array_addr(array_addr),
    .array_rdata(array_rdata), .op_word(op_word), .erase_sel(erase_sel),
    .prog_start(prog_start), .erase_start(erase_start),
    .erase_suspend(erase_suspend), .algo_done(algo_done),
    .algo_fail(algo_fail));
  // Clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      errors++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("checks %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask
  // Untouched array content
  function automatic logic [15:0] pat(logic [18:0] a);
    return a[15:0] ^ 16'h3c3c;
  endfunction
  // Write: strobe falls before select, data settles late
  task automatic wr(logic [18:0] a, logic [15:0] d);
    @(posedge clk);
    write_strobe_n <= 1'b0;
    addr_pin <= ~a;
    dq_in <= ~d;
    @(posedge clk);
    chip_select_n <= 1'b0;
    addr_pin <= a;
    @(posedge clk);
    dq_in <= d;
    repeat (2) @(posedge clk);
    chip_select_n <= 1'b1;
    write_strobe_n <= 1'b1;
    dq_in <= ~d;
    repeat (5) @(posedge clk);
    #1;
  endtask
  // Command write with junk in ignored bits
  task automatic cmd(logic [10:0] a, logic [7:0] d);
    wr({8'ha5, a}, {8'hc3, d});
  endtask
  task automatic unlock(logic [7:0] d);
    cmd(11'h555, 8'haa);
    cmd(11'h2aa, 8'h55);
    cmd(11'h555, d);
  endtask
  task automatic read(logic [18:0] a);
    @(posedge clk);
    addr_pin <= a;
    chip_select_n <= 1'b0;
    output_enable_n <= 1'b0;
    repeat (7) @(posedge clk);
    #1 rd = dq_out;
    @(posedge clk);
    chip_select_n <= 1'b1;
    output_enable_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask
  // Poll until bit 7 matches the expected data (at most 40 reads), then take the next read
  task automatic poll(logic [18:0] a, logic [15:0] exp);
    int n;
    n = 0;
    do begin
      read(a);
      n++;
    end while (rd[7] !== exp[7] && n < 40);
    read(a);
    check("final data", rd, exp);
  endtask
  task automatic erase(logic [18:0] a, logic [7:0] d);
    unlock(8'h80);
    cmd(11'h555, 8'haa);
    cmd(11'h2aa, 8'h55);
    wr(a, {8'hc3, d});
  endtask
  // Main sequence
  initial begin
    reset_n = 1'b0;
    chip_select_n = 1'b1;
    write_strobe_n = 1'b1;
    output_enable_n = 1'b1;
    addr_pin = '0;
    dq_in = '0;
    sector_protect = 128'h20;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    read(19'h0_1234);
    check("plain", rd, pat(19'h0_1234));
    cmd(11'h555, 8'haa);
    cmd(11'h123, 8'h55);
    cmd(11'h555, 8'h90);
    read(19'h0_0000);
    check("broken", rd, pat(19'h0_0000));
    unlock(8'h90);
    foreach (id_a[i]) begin
      read(id_a[i]);
      check("ident", rd, id_e[i]);
    end
    cmd(11'h0ab, 8'hf0);
    read(19'h0_0001);
    check("reset", rd, pat(19'h0_0001));
    unlock(8'hc0);
    wr(19'h1_2345, 16'h0001);
    check("burst on", 16'(burst_mode), 16'h0001);
    unlock(8'h90);
    read(19'h0_0003);
    check("mode id", rd, 16'h0001);
    cmd(11'h000, 8'hf0);
    erase(19'h0_4000, 8'h30);
    cmd(11'h000, 8'hb0);
    check("burst b0", 16'(erase_suspend), 16'h0000);
    poll(19'h0_4004, 16'hffff);
    unlock(8'hc0);
    wr(19'h1_2345, 16'h0000);
    check("burst off", 16'(burst_mode), 16'h0000);
    unlock(8'ha0);
    wr(19'h0_3210, 16'h5a80);
    read(19'h0_3210);
    check("prog poll", 16'(rd[7]), 16'h0000);
    poll(19'h0_3210, 16'h5a80);
    unlock(8'ha0);
    wr(19'h0_5084, 16'h0000);
    read(19'h0_5084);
    check("prot poll", 16'(rd[7]), 16'h0001);
    repeat (130) @(posedge clk);
    read(19'h0_5084);
    check("prot done", rd, pat(19'h0_5084));
    unlock(8'h20);
    cmd(11'h7ff, 8'ha0);
    wr(19'h0_3300, 16'h1234);
    poll(19'h0_3300, 16'h1234);
    cmd(11'h0f0, 8'h90);
    cmd(11'h00f, 8'h00);
    cmd(11'h7ff, 8'ha0);
    wr(19'h0_3301, 16'h0000);
    read(19'h0_3301);
    check("bypass exit", rd, pat(19'h0_3301));
    cmd(11'h000, 8'hb0);
    check("idle b0", 16'(erase_suspend), 16'h0000);
    erase(19'h0_7000, 8'h30);
    read(19'h0_7004);
    check("erase poll", 16'(rd[7]), 16'h0000);
    cmd(11'h000, 8'hb0);
    check("suspend", 16'(erase_suspend), 16'h0001);
    read(19'h0_7004);
    check("susp poll", 16'(rd[7]), 16'h0001);
    unlock(8'ha0);
    wr(19'h0_2020, 16'h0011);
    poll(19'h0_2020, 16'h0011);
    unlock(8'h90);
    read(19'h0_0001);
    check("susp ident", rd, `FCD_ID_PART);
    cmd(11'h000, 8'hf0);
    cmd(11'h000, 8'h30);
    check("resume", 16'(erase_suspend), 16'h0000);
    poll(19'h0_7004, 16'hffff);
    erase({8'ha5, 11'h555}, 8'h10);
    cmd(11'h000, 8'hb0);
    check("chip b0", 16'(erase_suspend), 16'h0000);
    poll(19'h0_0100, 16'hffff);
    read(19'h0_5084);
    check("chip prot", rd, pat(19'h0_5084));
    erase(19'h0_5000, 8'h30);
    read(19'h0_5004);
    check("prot erase", 16'(rd[7]), 16'h0000);
    repeat (40) @(posedge clk);
    read(19'h0_5004);
    check("prot erase end", rd, pat(19'h0_5004));
    complete_run();
  end
endmodule // tb
bind fcd_top fcd_props i_props (
  .clk(clk), .reset_n(reset_n), .addr_pin(addr_pin), .dq_in(dq_in),
  .chip_select_n(chip_select_n), .write_strobe_n(write_strobe_n),
  .output_enable_n(output_enable_n), .dq_oe(dq_oe),
  .sector_protect(sector_protect), .op_word(op_word),
  .erase_sel(erase_sel), .prog_start(prog_start),
  .erase_start(erase_start), .erase_suspend(erase_suspend),
  .burst_mode(burst_mode));
